// file: common/link_bist_pkg.sv
// Constants for the serial link self-test checker.
// Assumes one core clock domain plus one link (payload) clock domain.
//
// Notes on behaviour
// - Self test starts from the enable strap pin or from a register write.
// - Pin test clock is pixel clock or oscillator; register picks oscillator rate.
// - Clock select pin chooses the test clock source for pin-started tests.
// - While enable pin is high, request goes to serializer over back channel.
// - Back-channel request also wakes a powered-down serializer.
// - After both ends in test and lock, result goes high, checking starts.
// - Each recovered payload is compared with zeros; mismatches are counted.
// - Payload with 1 to 35 bit errors pulses result low half a period.
// - Enable low stops checking; result holds high if clean, else low.
// - Held result stays until new test, reset or power-down.
// - After enable drops, link returns to normal operation.
// - Link error count and receive lock status are readable.
package link_bist_pkg;
    localparam int PAYLOAD_W = 35;
    localparam int MAX_BIT_ERR = 35;
    localparam int CNT_W = 8;
    // Register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_ERRCNT = 8'h08;
    localparam logic [7:0] REG_LINKERR = 8'h0c;
    // Control fields
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_OSC_LSB = 4;
    localparam int OSC_SEL_W = 3;
    localparam logic [2:0] OSC_SEL_RESET = 3'h0;
    // Status fields
    localparam int ST_ACTIVE_BIT = 0;
    localparam int ST_RESULT_BIT = 1;
    localparam int ST_LOCK_BIT = 2;
    localparam int ST_DONE_BIT = 3;
    localparam int ST_CLKSRC_BIT = 4;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_RUN = 3'b100
    } bist_state_t;
endpackage : link_bist_pkg

// file: rtl/serial_link_bist_checker.sv
// Self-test checker of the receiving end of a serial video link.
// Assumes payloads arrive on link_clk with a valid strobe, lock from the
// receive PLL, and a register port on core_clk.
`timescale 1ns/1ps
module serial_link_bist_checker
    import link_bist_pkg::*;
(
    // Core clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Pins
    input wire logic self_test_enable_pin,
    input wire logic self_test_clock_select_pin,
    input wire logic pixel_clk_present,
    output logic pass_pin,
    // Back channel and oscillator control
    output logic back_channel_bist_req,
    output logic back_channel_wake,
    output logic use_internal_oscillator,
    output logic [link_bist_pkg::OSC_SEL_W-1:0] internal_oscillator_sel,
    output logic link_normal_mode,
    // Link side
    input wire logic link_clk,
    input wire logic link_rst,
    input wire logic rx_locked,
    input wire logic far_in_test,
    input wire logic payload_valid,
    input wire logic [link_bist_pkg::PAYLOAD_W-1:0] payload_data
);
    import link_bist_pkg::*;

    // ---------------- Core domain ----------------
    logic en_s1, en_s2, clk_sel_s1, clk_sel_s2, pix_s1, pix_s2;
    logic lock_c1, lock_c2, far_c1, far_c2;
    logic reg_start, next_reg_start;
    logic [OSC_SEL_W-1:0] osc_sel, next_osc_sel;
    bist_state_t state, next_state;
    logic result, next_result;
    logic done, next_done;
    logic run_req, next_run_req;
    logic pulse_tg_s1, pulse_tg_s2, pulse_tg_s3;
    logic err_pulse;
    logic [CNT_W-1:0] err_cnt, next_err_cnt;
    logic [CNT_W-1:0] link_err, next_link_err;
    logic lock_prev, next_lock_prev;
    logic pass_low, next_pass_low;
    logic [31:0] next_rdata;
    logic test_on;

    // Two-stage synchronisers for pins and link-side levels
    always_ff @(posedge core_clk) begin
        en_s1 <= self_test_enable_pin;
        en_s2 <= en_s1;
        clk_sel_s1 <= self_test_clock_select_pin;
        clk_sel_s2 <= clk_sel_s1;
        pix_s1 <= pixel_clk_present;
        pix_s2 <= pix_s1;
        lock_c1 <= rx_locked;
        lock_c2 <= lock_c1;
        far_c1 <= far_in_test;
        far_c2 <= far_c1;
    end

    // Either the strap or the control bit asks for a test
    assign test_on = en_s2 || reg_start;
    assign err_pulse = pulse_tg_s2 ^ pulse_tg_s3;

    // Next values for test sequencing and registers
    always_comb begin
        next_state = state;
        next_result = result;
        next_done = done;
        next_run_req = run_req;
        next_err_cnt = err_cnt;
        next_link_err = link_err;
        next_reg_start = reg_start;
        next_osc_sel = osc_sel;
        next_lock_prev = lock_c2;
        next_pass_low = 1'b0;
        if (reg_wr && reg_addr == REG_CTRL) begin
            next_reg_start = reg_wdata[CTRL_START_BIT];
            next_osc_sel = reg_wdata[CTRL_OSC_LSB +: OSC_SEL_W];
        end
        // Lock lost while the link is up counts as a link error
        if (lock_prev && !lock_c2 && link_err != '1) begin
            next_link_err = link_err + 8'h01;
        end
        case (state)
            ST_IDLE: begin
                if (test_on) begin
                    next_state = ST_WAIT;
                    next_err_cnt = '0;
                    next_done = 1'b0;
                    next_result = 1'b0;
                end
            end
            ST_WAIT: begin
                if (!test_on) begin
                    next_state = ST_IDLE;
                    next_done = 1'b1;
                end else if (lock_c2 && far_c2) begin
                    next_state = ST_RUN;
                    next_result = 1'b1;
                    next_run_req = 1'b1;
                end
            end
            ST_RUN: begin
                // Pin stays high between pulses so an outside counter sees each one
                if (err_pulse) begin
                    next_pass_low = 1'b1;
                    if (err_cnt != '1) begin
                        next_err_cnt = err_cnt + 8'h01;
                    end
                end
                if (!test_on) begin
                    next_state = ST_IDLE;
                    next_run_req = 1'b0;
                    next_done = 1'b1;
                    // Verdict: any bad payload, counted or reported by err_pulse in this cycle, fails
                    next_result = (err_cnt == '0) && !err_pulse;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // Register the core state
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            result <= 1'b0;
            done <= 1'b0;
            run_req <= 1'b0;
            err_cnt <= '0;
            link_err <= '0;
            reg_start <= 1'b0;
            osc_sel <= OSC_SEL_RESET;
            lock_prev <= 1'b0;
            pass_low <= 1'b0;
            reg_rdata <= '0;
        end else begin
            state <= next_state;
            result <= next_result;
            done <= next_done;
            run_req <= next_run_req;
            err_cnt <= next_err_cnt;
            link_err <= next_link_err;
            reg_start <= next_reg_start;
            osc_sel <= next_osc_sel;
            lock_prev <= next_lock_prev;
            pass_low <= next_pass_low;
            reg_rdata <= next_rdata;
        end
    end

    // Read mux; unmapped offsets read as zero
    always_comb begin
        next_rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                REG_CTRL: begin
                    next_rdata[CTRL_START_BIT] = reg_start;
                    next_rdata[CTRL_OSC_LSB +: OSC_SEL_W] = osc_sel;
                end
                REG_STATUS: begin
                    next_rdata[ST_ACTIVE_BIT] = (state != ST_IDLE);
                    next_rdata[ST_RESULT_BIT] = result;
                    next_rdata[ST_LOCK_BIT] = lock_c2;
                    next_rdata[ST_DONE_BIT] = done;
                    next_rdata[ST_CLKSRC_BIT] = use_internal_oscillator;
                end
                REG_ERRCNT: next_rdata[CNT_W-1:0] = err_cnt;
                REG_LINKERR: next_rdata[CNT_W-1:0] = link_err;
                default: next_rdata = '0;
            endcase
        end
    end

    // Outputs; the low pulse is one core cycle, half of a pixel period at most
    assign pass_pin = result && !pass_low;
    assign back_channel_bist_req = test_on;
    assign back_channel_wake = test_on && (state == ST_WAIT);
    // Select pin decides for pin tests; without pixel clock use oscillator
    assign use_internal_oscillator = en_s2 ? (clk_sel_s2 || !pix_s2) : !pix_s2;
    assign internal_oscillator_sel = osc_sel;
    assign link_normal_mode = (state == ST_IDLE);

    // ---------------- Link domain ----------------
    logic run_l1, run_l2, lock_l1, lock_l2;
    logic pulse_tg, next_pulse_tg;
    logic [5:0] bit_errs;

    // Run level and receive lock crossed into link domain; lock is not timed to link_clk
    always_ff @(posedge link_clk) begin
        run_l1 <= run_req;
        run_l2 <= run_l1;
        lock_l1 <= rx_locked;
        lock_l2 <= lock_l1;
    end

    // Count mismatched bits against the all-zero payload
    always_comb begin
        bit_errs = '0;
        for (int i = 0; i < PAYLOAD_W; i++) begin
            bit_errs = bit_errs + 6'(payload_data[i]);
        end
        next_pulse_tg = pulse_tg;
        // Lock comes from its link-side synchroniser, never straight from the pin
        if (run_l2 && lock_l2 && payload_valid && bit_errs != '0
            && bit_errs <= 6'(MAX_BIT_ERR)) begin
            next_pulse_tg = !pulse_tg;
        end
    end

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            pulse_tg <= 1'b0;
        end else begin
            pulse_tg <= next_pulse_tg;
        end
    end

    // Error toggle into core domain
    always_ff @(posedge core_clk) begin
        pulse_tg_s1 <= pulse_tg;
        pulse_tg_s2 <= pulse_tg_s1;
        pulse_tg_s3 <= pulse_tg_s2;
    end

    // ---------------- Checks ----------------
    // Run entry: waiting, far end in test and receiver locked
    sequence s_start;
        state == ST_WAIT && lock_c2 && far_c2 && test_on;
    endsequence

    // Stop of a run with no error seen, pending or counted
    sequence s_stop_clean;
        state == ST_RUN && !test_on && !err_pulse && err_cnt == '0;
    endsequence

    // Stop of a run that saw at least one bad payload
    sequence s_stop_dirty;
        state == ST_RUN && !test_on && (err_pulse || err_cnt != '0);
    endsequence

    // Bad payload reported to the core while running
    sequence s_bad_payload;
        state == ST_RUN && err_pulse;
    endsequence

    // Entry into the run and staying high in it
    a_result_rise: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_start |=> result && state == ST_RUN)
        else $error("result not raised on run start");

    a_run_high: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == ST_RUN) |-> result)
        else $error("result low during run");

    // One core cycle low per bad payload, then back high for the outside counter
    a_err_pulse: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_bad_payload |=> !pass_pin)
        else $error("error did not pulse pass low");

    a_pulse_end: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == ST_RUN && test_on && !err_pulse) |=> pass_pin)
        else $error("pass not high between pulses");

    a_pulse_in_run: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state != ST_RUN) |=> !pass_low)
        else $error("pulse outside a run");

    // Stop and the verdict that is held afterwards
    a_stop_check: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == ST_RUN && !test_on) |=> state == ST_IDLE && done)
        else $error("test did not stop");

    a_final_pass: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_stop_clean |=> pass_pin)
        else $error("clean run not held high");

    a_final_fail: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_stop_dirty |=> !result)
        else $error("failed run not held low");

    a_hold_result: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == ST_IDLE && !test_on) |=> $stable(result))
        else $error("held result changed");

    // Payload error counter: cleared on start, counts only in a run
    a_start_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == ST_IDLE && test_on) |=> err_cnt == '0 && !result)
        else $error("test start did not clear");

    a_err_count: assert property (@(posedge core_clk) disable iff (sys_rst)
        (s_bad_payload ##0 err_cnt != 8'hff) |=> err_cnt == $past(err_cnt) + 8'h01)
        else $error("bad payload not counted");

    a_idle_errcnt: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == ST_IDLE && !test_on) |=> $stable(err_cnt))
        else $error("error count moved while idle");

    // Back channel, clock source and link mode
    a_req_follow: assert property (@(posedge core_clk) disable iff (sys_rst)
        back_channel_bist_req == (en_s2 || reg_start))
        else $error("back channel request wrong");

    a_wake_req: assert property (@(posedge core_clk) disable iff (sys_rst)
        back_channel_wake |-> back_channel_bist_req)
        else $error("wake without request");

    a_wake_wait: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == ST_WAIT && test_on) |-> back_channel_wake)
        else $error("no wake while waiting");

    a_osc_pin: assert property (@(posedge core_clk) disable iff (sys_rst)
        (en_s2 && clk_sel_s2) |-> use_internal_oscillator)
        else $error("select pin ignored");

    a_normal_mode: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state != ST_IDLE && !test_on) |=> link_normal_mode)
        else $error("link not back to normal");

    // Link error counter counts each loss of lock
    a_lock_count: assert property (@(posedge core_clk) disable iff (sys_rst)
        (lock_prev && !lock_c2 && link_err != 8'hff)
        |=> link_err == $past(link_err) + 8'h01)
        else $error("link error not counted");

    // Link side: only a bad payload during a run flips the error toggle
    a_good_quiet: assert property (@(posedge link_clk) disable iff (link_rst)
        (payload_valid && bit_errs == 6'h00) |=> $stable(pulse_tg))
        else $error("clean payload flagged");

    a_bad_toggle: assert property (@(posedge link_clk) disable iff (link_rst)
        (run_l2 && lock_l2 && payload_valid && bit_errs != 6'h00 && bit_errs <= 6'h23)
        |=> pulse_tg != $past(pulse_tg))
        else $error("bad payload not flagged");
endmodule : serial_link_bist_checker

// file: testbench/serializer_model.sv
// Behavioural far-end serializer for the link self-test bench.
// Assumes the back-channel request is a level and errors are ordered by a toggle.
`timescale 1ns/1ps
module serializer_model
    import link_bist_pkg::*;
(
    // Link clock
    input wire logic link_clk,
    // Back channel from the checker
    input wire logic bist_req,
    input wire logic wake,
    // Error injection from the bench
    input wire logic inj_tgl,
    input wire logic [5:0] inj_bits,
    // Back-channel lock and CRC error events from the bench
    input wire logic bc_locked,
    input wire logic crc_tgl,
    // Forward link
    output logic far_in_test,
    output logic payload_valid,
    output logic [link_bist_pkg::PAYLOAD_W-1:0] payload_data,
    // Back-channel CRC error counters
    output logic [7:0] test_crc_cnt,
    output logic [7:0] func_crc_cnt
);
    logic inj_seen;
    logic crc_seen;

    // Known state before the first link edge
    initial begin
        far_in_test = 1'b0;
        payload_valid = 1'b0;
        payload_data = '0;
        inj_seen = 1'b0;
        crc_seen = 1'b0;
        test_crc_cnt = 8'h00;
        func_crc_cnt = 8'h00;
    end

    // Test counter counts only in test after lock; mission counter only outside
    always @(posedge link_clk) begin
        crc_seen <= crc_tgl;
        if (bist_req && !far_in_test) begin
            test_crc_cnt <= 8'h00;
        end else if (far_in_test && bc_locked && crc_tgl != crc_seen
            && test_crc_cnt != 8'hff) begin
            test_crc_cnt <= test_crc_cnt + 8'h01;
        end
        if (!far_in_test && bc_locked && crc_tgl != crc_seen && func_crc_cnt != 8'hff) begin
            func_crc_cnt <= func_crc_cnt + 8'h01;
        end
    end

    // The request alone brings the far end into test, wake adds nothing; one payload with inj_bits low bits set per toggle
    always @(posedge link_clk) begin
        far_in_test <= bist_req | (wake & bist_req);
        inj_seen <= inj_tgl;
        payload_valid <= far_in_test;
        if (!far_in_test)
            payload_data <= ~payload_data; // Idle data keeps moving, never trusted
        else if (inj_tgl != inj_seen)
            payload_data <= (35'h1 << inj_bits) - 35'h1;
        else
            payload_data <= '0;
    end
endmodule : serializer_model

// file: testbench/tb.sv
// Self-checking bench for the link self-test checker.
// Assumes the far-end model above and the register map of the package.
`timescale 1ns/1ps
module tb;
    import link_bist_pkg::*;
    logic core_clk = 0, link_clk = 0, sys_rst = 1, link_rst = 1;
    logic [7:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata, v;
    logic reg_wr = 0, reg_rd = 0, en_pin = 0, sel_pin = 0, pix = 1, rx_locked = 1;
    logic pass_pin, req, wake, use_osc, normal, far_in_test, payload_valid;
    logic [2:0] osc_sel;
    logic [PAYLOAD_W-1:0] payload_data;
    logic inj_tgl = 0;
    logic [5:0] inj_bits = 0;
    logic crc_tgl = 0, bc_lock = 0;
    logic [7:0] test_crc, func_crc;
    int n_fail = 0, cmp_count = 0, n_low = 0;

    // Clocks with unrelated phases
    initial forever #4 core_clk = ~core_clk;
    initial #3 forever #6 link_clk = ~link_clk;

    // Outside monitor counting low pulses of the result pin
    always @(negedge pass_pin) n_low++;

    serial_link_bist_checker uut (.core_clk(core_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .self_test_enable_pin(en_pin),
        .self_test_clock_select_pin(sel_pin), .pixel_clk_present(pix), .pass_pin(pass_pin),
        .back_channel_bist_req(req), .back_channel_wake(wake),
        .use_internal_oscillator(use_osc), .internal_oscillator_sel(osc_sel),
        .link_normal_mode(normal), .link_clk(link_clk), .link_rst(link_rst),
        .rx_locked(rx_locked), .far_in_test(far_in_test), .payload_valid(payload_valid),
        .payload_data(payload_data));
    serializer_model far (.link_clk(link_clk), .bist_req(req), .wake(wake),
        .inj_tgl(inj_tgl), .inj_bits(inj_bits), .far_in_test(far_in_test),
        .bc_locked(bc_lock), .crc_tgl(crc_tgl), .test_crc_cnt(test_crc),
        .func_crc_cnt(func_crc),
        .payload_valid(payload_valid), .payload_data(payload_data));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1;
        @(posedge core_clk);
        reg_wr <= 0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1;
        @(posedge core_clk);
        reg_rd <= 0;
        #1 d = reg_rdata;
    endtask : rd

    // Pin is looked at 1 ns after each edge, once it has settled
    task automatic wait_pass(input logic val);
        int i;
        i = 0;
        @(posedge core_clk);
        #1;
        while (i < 300 && pass_pin !== val) begin
            @(posedge core_clk);
            #1;
            i++;
        end
        chk(pass_pin, val);
        if (pass_pin !== val)
            conclude();
    endtask : wait_pass

    task automatic inject(input logic [5:0] n);
        @(posedge core_clk);
        inj_bits <= n;
        inj_tgl <= ~inj_tgl;
        repeat (20) @(posedge core_clk);
    endtask : inject

    task automatic t_errors;
        int base;
        en_pin <= 1;
        wait_pass(1);
        base = n_low;
        inject(6'd1);
        chk(pass_pin, 1);
        inject(6'd35);
        inject(6'd0);
        chk(n_low - base, 2);
        rd(REG_ERRCNT, v);
        chk(v, 2);
        @(posedge core_clk);
        en_pin <= 0;
        repeat (40) @(posedge core_clk);
        chk(pass_pin, 0);
        $display("errors test done");
    endtask : t_errors

    task automatic t_clean;
        sel_pin <= 1;
        en_pin <= 1;
        wait_pass(1);
        chk(req, 1);
        chk(use_osc, 1);
        chk(normal, 0);
        rd(REG_ERRCNT, v);
        chk(v, 0);
        @(posedge core_clk);
        en_pin <= 0;
        repeat (12) @(posedge core_clk);
        chk(pass_pin, 1);
        chk(normal, 1);
        chk(req, 0);
        rd(REG_STATUS, v);
        chk(v[ST_DONE_BIT], 1);
        @(posedge core_clk);
        sys_rst <= 1;
        repeat (4) @(posedge core_clk);
        sys_rst <= 0;
        @(posedge core_clk);
        #1;
        chk(pass_pin, 0);
        chk(normal, 1);
        $display("clean pin test done");
    endtask : t_clean

    task automatic t_reg_start;
        @(posedge core_clk);
        sel_pin <= 0;
        pix <= 0;
        repeat (4) @(posedge core_clk);
        chk(use_osc, 1);
        pix <= 1;
        wr(REG_CTRL, 32'h51);
        repeat (2) @(posedge core_clk);
        chk(osc_sel, 3'h5);
        chk(use_osc, 0);
        chk(req, 1);
        wait_pass(1);
        rd(REG_CTRL, v);
        chk(v, 32'h51);
        wr(REG_CTRL, 0);
        repeat (12) @(posedge core_clk);
        chk(pass_pin, 1);
        chk(normal, 1);
        $display("register start test done");
    endtask : t_reg_start

    task automatic t_lock;
        rx_locked <= 0;
        repeat (12) @(posedge core_clk);
        rd(REG_LINKERR, v);
        chk(v, 1);
        rd(REG_STATUS, v);
        chk(v[ST_LOCK_BIT], 0);
        rd(8'h10, v);
        chk(v, 0);
        @(posedge core_clk);
        rx_locked <= 1;
        $display("lock test done");
    endtask : t_lock

    task automatic crc_pulse;
        @(posedge core_clk);
        crc_tgl <= ~crc_tgl;
        repeat (4) @(posedge core_clk);
    endtask : crc_pulse

    // Far end back-channel CRC counters across entry and exit of a test
    task automatic t_crc;
        @(posedge core_clk);
        en_pin <= 1;
        repeat (12) @(posedge core_clk);
        chk(test_crc, 0);
        crc_pulse();
        chk(test_crc, 0);
        bc_lock <= 1;
        crc_pulse();
        crc_pulse();
        chk(test_crc, 2);
        chk(func_crc, 0);
        en_pin <= 0;
        repeat (12) @(posedge core_clk);
        crc_pulse();
        chk(test_crc, 2);
        chk(func_crc, 1);
        en_pin <= 1;
        repeat (12) @(posedge core_clk);
        chk(test_crc, 0);
        en_pin <= 0;
        repeat (12) @(posedge core_clk);
        $display("crc counter test done");
    endtask : t_crc

    // Main sequence
    initial begin
        repeat (16) @(posedge core_clk);
        sys_rst <= 0;
        link_rst <= 0;
        @(posedge core_clk);
        chk(pass_pin, 0);
        chk(normal, 1);
        t_errors();
        t_clean();
        t_reg_start();
        t_crc();
        t_lock();
        conclude();
    end
endmodule : tb
